// [rtl/otpwa_defs.svh]
// Offsets, field positions, reset values and timing figures of the word store access unit
`ifndef OTPWA_DEFS_SVH
`define OTPWA_DEFS_SVH
// Register offsets on the special function register port
`define OTPWA_OFS_CTRL 8'h00
`define OTPWA_OFS_PTR 8'h01
`define OTPWA_OFS_DH 8'h02
`define OTPWA_OFS_DL 8'h03
`define OTPWA_OFS_PTRH 8'h04
// Control and pointer-high bit positions
`define OTPWA_BIT_RD 0
`define OTPWA_BIT_WR 1
`define OTPWA_BIT_SUP 2
`define OTPWA_BIT_PHEN 7
// Store geometry and reset values
`define OTPWA_LAST_ADDR 8'h3f
`define OTPWA_WORDS 64
`define OTPWA_ERASED 16'hffff
`define OTPWA_RST_BYTE 8'h00
// Clock rate and access times in their own units
`define OTPWA_CLK_KHZ 250000
`define OTPWA_READ_NS 16
`define OTPWA_PROG_US 100
`define OTPWA_LV_A_MS 500
`define OTPWA_LV_B_MS 150
`endif

// [rtl/otpwa_pkg.sv]
// Types shared by the word store access unit
package otpwa_pkg;
   // Access sequencer states
   typedef enum logic [1:0]
   {
      OTPWA_IDLE = 2'b00,
      OTPWA_READ = 2'b01,
      OTPWA_PROG = 2'b10
   } otpwa_state_t;
   // One stored word
   typedef logic [15:0] otpwa_word_t;
endpackage

// [rtl/otpwa_array.sv]
// One-time-programmable array of 64 sixteen-bit words
`timescale 1ns/1ns
`include "otpwa_defs.svh"
module otpwa_array
   import otpwa_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [5:0] rd_addr,
   output otpwa_word_t rd_data,
   input wire logic prog_en,
   input wire logic [5:0] prog_addr,
   input wire otpwa_word_t prog_data
);
   otpwa_word_t mem_ff [`OTPWA_WORDS]; // Cell contents
   otpwa_word_t rd_data_ff; // Registered read port

   // Programming can only pull bits low; ones in the data leave cells alone
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         // Model starts blank; real cells keep their charge
         for (int i = 0; i < `OTPWA_WORDS; i++)
         begin
            mem_ff[i] <= `OTPWA_ERASED;
         end
      end
      else if (prog_en)
      begin
         mem_ff[prog_addr] <= mem_ff[prog_addr] & prog_data;
      end
   end

   // Read port, one cycle latency
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_data_ff <= `OTPWA_ERASED;
      end
      else
      begin
         rd_data_ff <= mem_ff[rd_addr];
      end
   end

   assign rd_data = rd_data_ff;
endmodule // otpwa_array

// [rtl/otpwa_top.sv]
// Register-driven read and program sequencer for the one-time-programmable word store
// Functional notes
// - 64 words of 16 bits, high/low bytes
// - Pointer above 3FH: request ignored
// - Read fetches word, clears request when done
// - Write programs word, clears request when done
// - Write ignored without 6V programming supply or low-voltage path enable
// - Read-only supply-high status bit
// - Access only while pointer-high bit 7 set
// - Low-voltage path A: 500 ms, doubled alternate
// - Low-voltage path B: 150 ms per word
// - Done: clear request, pointer increments, stops 3FH
// - Both request bits together: invalid, ignored
`timescale 1ns/1ns
`include "otpwa_defs.svh"
module otpwa_top
   import otpwa_pkg::*;
#(
   parameter bit HAS_PTR_HIGH = 1'b1,
   parameter int unsigned PROG_CYC = (`OTPWA_PROG_US * `OTPWA_CLK_KHZ + 999) / 1000,
   parameter int unsigned LV_A_CYC = `OTPWA_LV_A_MS * `OTPWA_CLK_KHZ,
   parameter int unsigned LV_B_CYC = `OTPWA_LV_B_MS * `OTPWA_CLK_KHZ
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic store_busy,
   input wire logic programming_supply,
   input wire logic lowvolt_path_en,
   input wire logic lowvolt_variant_b,
   input wire logic cpu_clock_select
);
   // Read access time, rounded up to whole cycles
   localparam int unsigned READ_CYC = (`OTPWA_READ_NS * `OTPWA_CLK_KHZ + 999999) / 1000000;

   otpwa_state_t state_ff; // Sequencer state
   logic [31:0] cnt_ff; // Cycles left in the access
   logic rd_req_ff; // read_request bit
   logic wr_req_ff; // write_request bit
   logic [7:0] ptr_ff; // store_word_pointer
   logic [7:0] ptrh_ff; // pointer-high register
   logic [7:0] dh_ff; // store_data_high
   logic [7:0] dl_ff; // store_data_low
   logic [5:0] op_addr_ff; // Address frozen at start
   otpwa_word_t op_word_ff; // Data frozen at start
   logic [7:0] sfr_rdata_ff; // Read data to the CPU
   logic busy_ff; // Access in flight
   otpwa_word_t arr_word; // Array read port
   logic ctrl_wr; // Control register written
   logic access_ok; // Pointer and enable allow access
   logic start_rd; // Read accepted
   logic start_wr; // Write accepted
   logic done; // Last cycle of an access
   logic [31:0] wr_len; // Programming length for this path

   // Word address in range
   function automatic logic addr_ok(input logic [7:0] p);
      return p <= `OTPWA_LAST_ADDR;
   endfunction

   // Next pointer, held at the last word
   function automatic logic [7:0] ptr_step(input logic [7:0] p);
      return (p >= `OTPWA_LAST_ADDR) ? `OTPWA_LAST_ADDR : 8'(p + 8'h01);
   endfunction

   assign ctrl_wr = sfr_wr && (sfr_addr == `OTPWA_OFS_CTRL);
   assign access_ok = addr_ok(ptr_ff) && (!HAS_PTR_HIGH || ptrh_ff[`OTPWA_BIT_PHEN]);
   // Both bits in one write is a malformed request
   assign start_rd = ctrl_wr && (state_ff == OTPWA_IDLE) && access_ok && sfr_wdata[`OTPWA_BIT_RD]
      && !sfr_wdata[`OTPWA_BIT_WR];
   assign start_wr = ctrl_wr && (state_ff == OTPWA_IDLE) && access_ok && sfr_wdata[`OTPWA_BIT_WR]
      && !sfr_wdata[`OTPWA_BIT_RD] && (programming_supply || lowvolt_path_en);
   assign done = (state_ff != OTPWA_IDLE) && (cnt_ff == 32'h0);

   // Supply path is fast; low-voltage paths take the long routine times
   always_comb
   begin
      if (programming_supply)
      begin
         wr_len = PROG_CYC;
      end
      else if (lowvolt_variant_b)
      begin
         wr_len = LV_B_CYC;
      end
      else if (cpu_clock_select)
      begin
         wr_len = 32'(LV_A_CYC * 2);
      end
      else
      begin
         wr_len = LV_A_CYC;
      end
   end

   // Sequencer and its down-counter
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= OTPWA_IDLE;
         cnt_ff <= 32'h0;
      end
      else if (start_rd)
      begin
         state_ff <= OTPWA_READ;
         cnt_ff <= 32'(READ_CYC - 1);
      end
      else if (start_wr)
      begin
         state_ff <= OTPWA_PROG;
         cnt_ff <= wr_len - 32'h1;
      end
      else if (done)
      begin
         state_ff <= OTPWA_IDLE;
      end
      else if (state_ff != OTPWA_IDLE)
      begin
         cnt_ff <= cnt_ff - 32'h1;
      end
   end

   // Request bits: software sets, hardware clears at the end
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_req_ff <= 1'b0;
         wr_req_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else
      begin
         // Start only in idle, so set and clear never meet
         if (start_rd || start_wr)
         begin
            rd_req_ff <= start_rd;
            wr_req_ff <= start_wr;
            busy_ff <= 1'b1;
         end
         else if (done)
         begin
            rd_req_ff <= 1'b0;
            wr_req_ff <= 1'b0;
            busy_ff <= 1'b0;
         end
      end
   end

   // Operands frozen so mid-access register writes cannot corrupt it
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         op_addr_ff <= 6'h00;
         op_word_ff <= `OTPWA_ERASED;
      end
      else if (start_rd || start_wr)
      begin
         op_addr_ff <= ptr_ff[5:0];
         op_word_ff <= {dh_ff, dl_ff};
      end
   end

   // Pointer: auto-step after each access wins over a CPU write
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ptr_ff <= `OTPWA_RST_BYTE;
         ptrh_ff <= `OTPWA_RST_BYTE;
      end
      else
      begin
         if (done)
         begin
            ptr_ff <= ptr_step({2'b00, op_addr_ff});
         end
         else if (sfr_wr && (sfr_addr == `OTPWA_OFS_PTR))
         begin
            ptr_ff <= sfr_wdata;
         end
         if (sfr_wr && (sfr_addr == `OTPWA_OFS_PTRH))
         begin
            ptrh_ff <= sfr_wdata;
         end
      end
   end

   // Data bytes: fetched word wins over a CPU write in the same cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         dh_ff <= `OTPWA_RST_BYTE;
         dl_ff <= `OTPWA_RST_BYTE;
      end
      else if (done && (state_ff == OTPWA_READ))
      begin
         dh_ff <= arr_word[15:8];
         dl_ff <= arr_word[7:0];
      end
      else if (sfr_wr && (sfr_addr == `OTPWA_OFS_DH))
      begin
         dh_ff <= sfr_wdata;
      end
      else if (sfr_wr && (sfr_addr == `OTPWA_OFS_DL))
      begin
         dl_ff <= sfr_wdata;
      end
   end

   // Register read-back, one cycle behind the address; unmapped reads zero
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sfr_rdata_ff <= `OTPWA_RST_BYTE;
      end
      else
      begin
         case (sfr_addr)
            `OTPWA_OFS_CTRL: sfr_rdata_ff <= {5'h00, programming_supply, wr_req_ff, rd_req_ff};
            `OTPWA_OFS_PTR: sfr_rdata_ff <= ptr_ff;
            `OTPWA_OFS_DH: sfr_rdata_ff <= dh_ff;
            `OTPWA_OFS_DL: sfr_rdata_ff <= dl_ff;
            `OTPWA_OFS_PTRH: sfr_rdata_ff <= ptrh_ff;
            default: sfr_rdata_ff <= 8'h00;
         endcase
      end
   end

   assign sfr_rdata = sfr_rdata_ff;
   assign store_busy = busy_ff;

   // Cell array; programming commits on the last cycle
   otpwa_array u_array
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .rd_addr(op_addr_ff),
      .rd_data(arr_word),
      .prog_en(done && (state_ff == OTPWA_PROG)),
      .prog_addr(op_addr_ff),
      .prog_data(op_word_ff)
   );

   // Elapsed cycles and expected length, for the timing check only
   logic [31:0] elap_ff;
   logic [31:0] exp_ff;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         elap_ff <= 32'h0;
         exp_ff <= 32'h0;
      end
      else if (start_rd || start_wr)
      begin
         elap_ff <= 32'h1;
         exp_ff <= start_wr ? wr_len : 32'(READ_CYC);
      end
      else if (state_ff != OTPWA_IDLE)
      begin
         elap_ff <= elap_ff + 32'h1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   addr_guard_a: assert property (ctrl_wr && !addr_ok(ptr_ff) |=> state_ff == $past(state_ff))
      else $error("out-of-range pointer started an access");
   both_req_a: assert property (ctrl_wr && (sfr_wdata[1:0] == 2'b11) && (state_ff == OTPWA_IDLE)
      |=> state_ff == OTPWA_IDLE && !rd_req_ff && !wr_req_ff)
      else $error("double request was not ignored");
   supply_gate_a: assert property (ctrl_wr && !programming_supply && !lowvolt_path_en |=> !$rose(wr_req_ff))
      else $error("write started without programming supply");
   ptrh_gate_a: assert property (ctrl_wr && HAS_PTR_HIGH && !ptrh_ff[7] |=> state_ff == $past(state_ff))
      else $error("access started with pointer-high enable clear");
   read_len_a: assert property ($rose(rd_req_ff) |-> rd_req_ff[*4] ##1 !rd_req_ff)
      else $error("read request not cleared after four cycles");
   read_data_a: assert property (done && state_ff == OTPWA_READ |=> {dh_ff, dl_ff} == $past(arr_word))
      else $error("fetched word not placed in data bytes");
   wr_clear_a: assert property ($fell(wr_req_ff) |-> $past(done) && $past(state_ff) == OTPWA_PROG)
      else $error("write request cleared before programming ended");
   ptr_step_a: assert property (done |=> ptr_ff == ptr_step({2'b00, $past(op_addr_ff)}))
      else $error("pointer did not step after access");
   supply_bit_a: assert property (sfr_addr == `OTPWA_OFS_CTRL |=> sfr_rdata_ff[2] == $past(programming_supply))
      else $error("supply status bit wrong");
   op_time_a: assert property (done |-> elap_ff == exp_ff)
      else $error("access length differs from its path time");
   idle_hold_a: assert property (state_ff == OTPWA_IDLE && !start_rd && !start_wr |=> state_ff == OTPWA_IDLE)
      else $error("access began without a request");

   read_seen_c: cover property (done && state_ff == OTPWA_READ);
   prog_seen_c: cover property (done && state_ff == OTPWA_PROG);
   both_seen_c: cover property (ctrl_wr && sfr_wdata[1:0] == 2'b11);
   top_addr_c: cover property (done && op_addr_ff == 6'h3f);
endmodule // otpwa_top

// [test/otpwa_sfr_host.sv]
// Software-side model that writes and reads the store's special function registers
`timescale 1ns/1ns
module otpwa_sfr_host
(
   input wire logic ref_clk,
   output logic [7:0] sfr_addr,
   output logic sfr_wr,
   output logic [7:0] sfr_wdata,
   output logic look
);
   // Idle bus at time zero, no strobe before reset release
   initial
   begin
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_wdata = 8'h00;
      look = 1'b0;
   end

   // One-cycle write strobe, launched off the sampling edge
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask

   // Present an address; read data is registered, so it shows one edge later
   task automatic peek(input logic [7:0] a);
      @(negedge ref_clk);
      sfr_addr = a;
      look = 1'b1;
      @(negedge ref_clk);
      look = 1'b0;
   endtask
endmodule // otpwa_sfr_host

// [test/test_otp_word_store_access.sv]
// Self-checking bench for the word store access unit
`timescale 1ns/1ns
module test_otp_word_store_access;
   import otpwa_pkg::*;
   logic ref_clk = 1'b0; // Bench clock, 4 ns period
   logic rst = 1'b1; // Held for 16 cycles
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic sfr_wr, store_busy, look;
   logic seen = 1'b0; // Read data due at this falling edge
   logic supply = 1'b0, lv_en = 1'b0, lv_b = 1'b0, clk_sel = 1'b0;
   logic converter_enable = 1'b1; // Software's converter switch, off around accesses
   logic [7:0] exp_q[$]; // Expected read-back bytes, oldest first
   int n_fail = 0;
   int checks_done = 0;
   otpwa_word_t w1, w2;

   // Short program counts keep the run brief
   otpwa_top #(.PROG_CYC(5), .LV_A_CYC(20), .LV_B_CYC(10)) dut (.ref_clk(ref_clk), .rst(rst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .store_busy(store_busy), .programming_supply(supply), .lowvolt_path_en(lv_en),
      .lowvolt_variant_b(lv_b), .cpu_clock_select(clk_sel));
   otpwa_sfr_host host (.ref_clk(ref_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .look(look));

   // Free-running clock
   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end

   // Verdict and end of run, shared with the watchdog
   task automatic conclude();
      if (n_fail == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Single comparison point
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      checks_done++;
      if (got !== want)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, want);
      end
   endtask

   // Note the expected byte, then let the host read
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.peek(a);
   endtask

   // Write control, then count busy cycles under a bound
   task automatic go(input logic [7:0] c, input int e);
      int n = 0;
      host.put(8'h00, c);
      while (store_busy === 1'b1 && n < 200)
      begin
         n++;
         @(negedge ref_clk);
      end
      check(8'(n), 8'(e));
   endtask

   // Monitor: compares each registered read against the oldest note
   always @(posedge ref_clk) seen <= look;
   always @(negedge ref_clk)
   begin
      if (seen === 1'b1 && exp_q.size() > 0)
         check(sfr_rdata, exp_q.pop_front());
      // Software must keep the converter off while an access runs
      if (store_busy === 1'b1)
         check({7'h00, converter_enable}, 8'h00);
   end

   // Watchdog, far beyond the expected run of under a thousand ns
   initial
   begin
      #20000;
      n_fail++;
      conclude();
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'h92ca));
      w1 = otpwa_word_t'($urandom);
      w2 = otpwa_word_t'($urandom);
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      converter_enable = 1'b0;
      rd(8'h00, 8'h00);
      rd(8'h05, 8'h00);
      go(8'h01, 0);
      host.put(8'h04, 8'h80);
      host.put(8'h01, 8'h10);
      go(8'h01, 4);
      rd(8'h02, 8'hff);
      rd(8'h03, 8'hff);
      rd(8'h01, 8'h11);
      host.put(8'h01, 8'h10);
      host.put(8'h02, w1[15:8]);
      host.put(8'h03, w1[7:0]);
      go(8'h02, 0);
      rd(8'h01, 8'h10);
      supply = 1'b1;
      rd(8'h00, 8'h04);
      go(8'h03, 0);
      go(8'h02, 5);
      rd(8'h01, 8'h11);
      // Low-voltage path can only clear bits; bits already programmed stay low
      supply = 1'b0;
      lv_en = 1'b1;
      lv_b = 1'b1;
      host.put(8'h01, 8'h10);
      host.put(8'h02, w2[15:8]);
      host.put(8'h03, w2[7:0]);
      go(8'h02, 10);
      host.put(8'h01, 8'h10);
      go(8'h01, 4);
      rd(8'h02, w1[15:8] & w2[15:8]);
      rd(8'h03, w1[7:0] & w2[7:0]);
      // First low-voltage path at the normal clock setting
      lv_b = 1'b0;
      host.put(8'h01, 8'h20);
      go(8'h02, 20);
      // Last word, slow clock setting doubles the time
      clk_sel = 1'b1;
      host.put(8'h01, 8'h3f);
      host.put(8'h02, 8'hff);
      host.put(8'h03, 8'h5a);
      go(8'h02, 40);
      rd(8'h01, 8'h3f);
      host.put(8'h02, 8'h00);
      go(8'h01, 4);
      rd(8'h02, 8'hff);
      rd(8'h03, 8'h5a);
      // Poll the request bit itself: set while fetching, clear afterwards
      host.put(8'h00, 8'h01);
      rd(8'h00, 8'h01);
      repeat (4) @(negedge ref_clk);
      rd(8'h00, 8'h00);
      host.put(8'h01, 8'h40);
      go(8'h01, 0);
      go(8'h02, 0);
      // Second reset in mid-run
      converter_enable = 1'b1;
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      rd(8'h04, 8'h00);
      rd(8'h00, 8'h00);
      repeat (2) @(negedge ref_clk);
      conclude();
   end
endmodule // test_otp_word_store_access
